//--- rtl/ecs_ext_control.sv
// External control port: status outputs, command inputs, sync lock, AXI4-Lite registers
// Functional notes
// - Power-state output low while power source off, high while on.
// - Output-state line low while output disabled, high while enabled.
// - Limiter output high when any peak, average or power limiter operates.
// - Busy output low in normal operation, high while processing is busy.
// - Two sequence sync outputs, bits zero and one, set by running sequence; here only a write to the SEQSYNC register sets them.
// - Falling edge on sequence-stop input stops the running sequence.
// - Falling edge on sequence-hold input puts running sequence on hold.
// - Status outputs always active and updated, regardless of any enable.
// - In external-sync modes, lock only while sync lies within 40 to 999.9 Hz.
// - No adjustable phase offset; lock has a fixed phase relation.
// - Source select picks external sync input or mains line as reference.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
module ecs_ext_control #(
   parameter logic [ecs_pkg::PER_W-1:0] MIN_PERIOD_CYC = ecs_pkg::SYNC_PMIN_CYC, // Least sync period
   parameter logic [ecs_pkg::PER_W-1:0] MAX_PERIOD_CYC = ecs_pkg::SYNC_PMAX_CYC // Longest sync period
) (
   input wire logic mclk, // 125 MHz clock
   input wire logic resetn, // Async reset, active low
   input wire logic [ecs_pkg::ADDR_W-1:0] awaddr, // AXI write address
   input wire logic awvalid, // AXI write address valid
   output logic awready, // AXI write address ready
   input wire logic [31:0] wdata, // AXI write data
   input wire logic [3:0] wstrb, // AXI write strobes
   input wire logic wvalid, // AXI write data valid
   output logic wready, // AXI write data ready
   output logic [1:0] bresp, // AXI write response
   output logic bvalid, // AXI write response valid
   input wire logic bready, // AXI write response ready
   input wire logic [ecs_pkg::ADDR_W-1:0] araddr, // AXI read address
   input wire logic arvalid, // AXI read address valid
   output logic arready, // AXI read address ready
   output logic [31:0] rdata, // AXI read data
   output logic [1:0] rresp, // AXI read response
   output logic rvalid, // AXI read valid
   input wire logic rready, // AXI read ready
   input wire logic [ecs_pkg::NCMD-1:0] cmdPinN, // Command lines, falling edge acts
   input wire logic extSyncIn, // External sync input
   input wire logic mainsRef, // Mains line reference
   input wire logic powerIsOn, // Power source is on
   input wire logic [3:0] limiterActive, // Peak+, peak-, average, power limiters
   input wire logic procBusy, // Internal processing busy
   output logic statPowerOn, // Power-state pin
   output logic statOutputOn, // Output-state pin, also output enable
   output logic statLimiter, // Limiter pin
   output logic statBusy, // Busy pin
   output logic [1:0] statSeqSync, // Sequence sync pins
   output logic seqRunning, // Sequence running
   output logic seqHeld, // Sequence on hold
   output logic [1:0] seqBranch, // Branch taken, one-cycle pulse
   output logic syncLocked, // Output frequency locked to source
   output logic syncTick, // Lock reference edge, one-cycle pulse
   output logic irq // Interrupt, level
);
   import ecs_pkg::*;

   typedef struct packed {
      logic awHave;
      logic wHave;
      logic [ADDR_W-1:0] awAddr;
      logic [31:0] wData;
      logic wLow;
      logic wHigh;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic srcSel;
      ecs_mode_t mode;
      logic [1:0] seqSync;
      logic outOn;
      ecs_seq_t seq;
      logic seqRunning;
      logic seqHeld;
      logic [1:0] branch;
      logic statPower;
      logic statLimiter;
      logic statBusy;
      logic locked;
      logic syncTick;
      logic [NEV-1:0] intStat;
      logic [NEV-1:0] intEn;
      logic irq;
   } ecs_top_st_t;

   ecs_top_st_t r;
   ecs_top_st_t next_r;
   ecs_core_if core ();

   logic wrDo;
   logic lockNow;
   logic [NCMD-1:0] swCmd;
   logic [NCMD-1:0] cmd;
   logic [NEV-1:0] clr;
   logic [NEV-1:0] ev;
   logic [1:0] modeBits;

   ecs_edge_detect u_edge (
      .mclk(mclk),
      .resetn(resetn),
      .cmdPinN(cmdPinN),
      .core(core.edge_src)
   );

   ecs_freq_meter #(
      .MIN_PERIOD_CYC(MIN_PERIOD_CYC),
      .MAX_PERIOD_CYC(MAX_PERIOD_CYC)
   ) u_meter (
      .mclk(mclk),
      .resetn(resetn),
      .extSyncIn(extSyncIn),
      .mainsRef(mainsRef),
      .srcSel(r.srcSel),
      .core(core.meter)
   );

   always_comb begin
      next_r = r;
      swCmd = '0;
      clr = '0;
      modeBits = r.wData[CTRL_MODE_LSB +: 2];
      next_r.branch = 2'h0;

      // Write address and data are taken in either order
      if (awvalid && r.awready) begin
         next_r.awHave = 1'b1;
         next_r.awAddr = awaddr;
      end
      // Strobes are kept with the data: the master may drop them once wready is seen
      if (wvalid && r.wready) begin
         next_r.wHave = 1'b1;
         next_r.wData = wdata;
         next_r.wLow = wstrb[0];
         next_r.wHigh = wstrb[1];
      end
      if (r.bvalid && bready) begin
         next_r.bvalid = 1'b0;
      end
      wrDo = r.awHave && r.wHave && !r.bvalid;
      if (wrDo) begin
         next_r.awHave = 1'b0;
         next_r.wHave = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = RESP_OKAY;
         case (r.awAddr)
            REG_CTRL: begin
               if (r.wLow) begin
                  next_r.srcSel = r.wData[CTRL_SRC_BIT];
                  next_r.mode = (modeBits == 2'h3) ? MODE_INTERNAL : ecs_mode_t'(modeBits);
               end
            end
            REG_CMD: begin
               if (r.wLow) begin
                  swCmd = r.wData[NCMD-1:0];
               end
            end
            REG_SEQSYNC: begin
               if (r.wLow) begin
                  next_r.seqSync = r.wData[1:0];
               end
            end
            REG_INT_EN: begin
               if (r.wLow) begin
                  next_r.intEn[7:0] = r.wData[7:0];
               end
               if (r.wHigh) begin
                  next_r.intEn[NEV-1] = r.wData[8];
               end
            end
            REG_INT_CLR: begin
               clr = r.wData[NEV-1:0];
            end
            REG_STATE, REG_PERIOD, REG_INT_STAT: begin
            end
            default: begin
               next_r.bresp = RESP_SLVERR;
            end
         endcase
      end
      next_r.awready = !next_r.awHave && !next_r.bvalid;
      next_r.wready = !next_r.wHave && !next_r.bvalid;

      // Read channel
      if (r.rvalid && rready) begin
         next_r.rvalid = 1'b0;
      end
      if (arvalid && r.arready) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = RESP_OKAY;
         next_r.rdata = 32'h0;
         case (araddr)
            REG_CTRL: next_r.rdata[2:0] = {r.mode, r.srcSel};
            REG_STATE: next_r.rdata[6:0] = {r.locked, r.seq, r.statBusy, r.statLimiter, r.outOn, r.statPower};
            REG_SEQSYNC: next_r.rdata[1:0] = r.seqSync;
            REG_PERIOD: next_r.rdata[PER_W-1:0] = core.period;
            REG_INT_STAT: next_r.rdata[NEV-1:0] = r.intStat;
            REG_INT_EN: next_r.rdata[NEV-1:0] = r.intEn;
            REG_CMD, REG_INT_CLR: begin
            end
            default: next_r.rresp = RESP_SLVERR;
         endcase
      end
      next_r.arready = !next_r.rvalid;

      // Status pins follow their sources every cycle
      next_r.statPower = powerIsOn;
      next_r.statLimiter = |limiterActive;
      next_r.statBusy = procBusy;

      // Pin edges and software commands act alike
      cmd = core.cmdFall | swCmd;
      // Off beats on; the output never stays enabled without power
      if (cmd[CMD_OUT_ON] && powerIsOn) begin
         next_r.outOn = 1'b1;
      end
      if (cmd[CMD_OUT_OFF] || !powerIsOn) begin
         next_r.outOn = 1'b0;
      end

      // Hold only from run, start from idle or hold, branches only while running
      case (r.seq)
         SEQ_IDLE: begin
            if (cmd[CMD_SEQ_START]) begin
               next_r.seq = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            next_r.branch = cmd[CMD_BRANCH_LSB +: 2];
            if (cmd[CMD_SEQ_HOLD]) begin
               next_r.seq = SEQ_HOLD;
            end
         end
         SEQ_HOLD: begin
            if (cmd[CMD_SEQ_START]) begin
               next_r.seq = SEQ_RUN;
            end
         end
         default: begin
            next_r.seq = SEQ_IDLE;
         end
      endcase
      // Stop beats every other command
      if (cmd[CMD_SEQ_STOP]) begin
         next_r.seq = SEQ_IDLE;
         next_r.branch = 2'h0;
      end
      // Sequence flags follow the next state so they line up with it
      next_r.seqRunning = (next_r.seq == SEQ_RUN);
      next_r.seqHeld = (next_r.seq == SEQ_HOLD);

      // Lock only in an external-sync mode with the source in window
      lockNow = (r.mode != MODE_INTERNAL) && core.inRange;
      next_r.locked = lockNow;
      next_r.syncTick = core.srcTick && lockNow;

      // Set wins over clear
      ev = {r.locked && !lockNow, lockNow && !r.locked, cmd};
      next_r.intStat = (r.intStat & ~clr) | ev;
      next_r.irq = |(next_r.intStat & next_r.intEn);
   end

   // Asynchronous reset loads constants only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.srcSel <= CTRL_SRC_RST;
         r.mode <= MODE_INTERNAL;
         r.seq <= SEQ_IDLE;
         r.seqSync <= SEQSYNC_RST;
         r.intEn <= INT_EN_RST;
      end else begin
         r <= next_r;
      end
   end

   assign awready = r.awready;
   assign wready = r.wready;
   assign bvalid = r.bvalid;
   assign bresp = r.bresp;
   assign arready = r.arready;
   assign rvalid = r.rvalid;
   assign rdata = r.rdata;
   assign rresp = r.rresp;
   assign statPowerOn = r.statPower;
   assign statOutputOn = r.outOn;
   assign statLimiter = r.statLimiter;
   assign statBusy = r.statBusy;
   assign statSeqSync = r.seqSync;
   assign seqRunning = r.seqRunning;
   assign seqHeld = r.seqHeld;
   assign seqBranch = r.branch;
   assign syncLocked = r.locked;
   assign syncTick = r.syncTick;
   assign irq = r.irq;
endmodule // ecs_ext_control

//--- shared/ecs_pkg.sv
// Constants, register map and types of the external control port
package ecs_pkg;
   localparam int CLK_HZ = 125_000_000;
   // Sync lock window, frequencies in units of 0.1 Hz
   localparam int SYNC_FMIN_DHZ = 400;
   localparam int SYNC_FMAX_DHZ = 9999;
   localparam int PER_W = 22;
   // Longest period rounds down, least period rounds up
   localparam int SYNC_PMAX_INT = (CLK_HZ * 10) / SYNC_FMIN_DHZ;
   localparam int SYNC_PMIN_INT = (CLK_HZ * 10 + SYNC_FMAX_DHZ - 1) / SYNC_FMAX_DHZ;
   localparam logic [PER_W-1:0] SYNC_PMAX_CYC = PER_W'(SYNC_PMAX_INT);
   localparam logic [PER_W-1:0] SYNC_PMIN_CYC = PER_W'(SYNC_PMIN_INT);

   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] REG_CMD = 5'h04;
   localparam logic [ADDR_W-1:0] REG_STATE = 5'h08;
   localparam logic [ADDR_W-1:0] REG_SEQSYNC = 5'h0c;
   localparam logic [ADDR_W-1:0] REG_PERIOD = 5'h10;
   localparam logic [ADDR_W-1:0] REG_INT_STAT = 5'h14;
   localparam logic [ADDR_W-1:0] REG_INT_EN = 5'h18;
   localparam logic [ADDR_W-1:0] REG_INT_CLR = 5'h1c;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // CTRL fields
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam logic CTRL_SRC_RST = 1'b0;

   // Command lines and CMD register bits share one numbering
   localparam int NCMD = 7;
   localparam int CMD_OUT_OFF = 0;
   localparam int CMD_OUT_ON = 1;
   localparam int CMD_SEQ_START = 2;
   localparam int CMD_SEQ_STOP = 3;
   localparam int CMD_SEQ_HOLD = 4;
   localparam int CMD_BRANCH_LSB = 5;

   // Interrupt events: bits 0..6 are the commands
   localparam int NEV = 9;
   localparam int EV_LOCK_GAIN = 7;
   localparam int EV_LOCK_LOSS = 8;
   localparam logic [NEV-1:0] INT_EN_RST = 9'h000;
   localparam logic [1:0] SEQSYNC_RST = 2'h0;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_RUN = 2'b01,
      SEQ_HOLD = 2'b10
   } ecs_seq_t;

   typedef enum logic [1:0] {
      MODE_INTERNAL = 2'b00,
      MODE_ACDC_EXTERNAL_SYNC = 2'b01,
      MODE_AC_EXTERNAL_SYNC = 2'b10
   } ecs_mode_t;
endpackage

//--- shared/ecs_core_if.sv
// Internal carrier from the edge detector and frequency meter to the core
interface ecs_core_if;
   logic [ecs_pkg::NCMD-1:0] cmdFall;
   logic [ecs_pkg::PER_W-1:0] period;
   logic inRange;
   logic srcTick;
   modport edge_src(output cmdFall);
   modport meter(output period, output inRange, output srcTick);
   modport core(input cmdFall, input period, input inRange, input srcTick);
endinterface

//--- rtl/ecs_edge_detect.sv
// Two-stage synchroniser and falling-edge detector for the command lines
module ecs_edge_detect (
   input wire logic mclk, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic [ecs_pkg::NCMD-1:0] cmdPinN, // Command lines, idle high
   ecs_core_if.edge_src core // Falling-edge pulses
);
   import ecs_pkg::*;

   typedef struct packed {
      logic [NCMD-1:0] s1;
      logic [NCMD-1:0] s2;
      logic [NCMD-1:0] prev;
   } ecs_edge_st_t;

   ecs_edge_st_t r;
   ecs_edge_st_t next_r;

   always_comb begin
      next_r = r;
      next_r.s1 = cmdPinN;
      next_r.s2 = r.s1;
      next_r.prev = r.s2;
   end

   // Lines idle high, so reset to high to avoid a false edge
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '1;
      end else begin
         r <= next_r;
      end
   end

   assign core.cmdFall = r.prev & ~r.s2;
endmodule // ecs_edge_detect

//--- rtl/ecs_freq_meter.sv
// Period meter and lock window check for the selected sync source
module ecs_freq_meter #(
   parameter logic [ecs_pkg::PER_W-1:0] MIN_PERIOD_CYC = ecs_pkg::SYNC_PMIN_CYC,
   parameter logic [ecs_pkg::PER_W-1:0] MAX_PERIOD_CYC = ecs_pkg::SYNC_PMAX_CYC
) (
   input wire logic mclk, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic extSyncIn, // External logic-level sync input
   input wire logic mainsRef, // Mains line reference
   input wire logic srcSel, // 0 external, 1 mains line
   ecs_core_if.meter core // Period and lock window result
);
   import ecs_pkg::*;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic prev;
      logic sel;
      logic seen;
      logic inRange;
      logic tick;
      logic [PER_W-1:0] cnt;
      logic [PER_W-1:0] period;
   } ecs_meter_st_t;

   ecs_meter_st_t r;
   ecs_meter_st_t next_r;
   logic lvl;

   always_comb begin
      next_r = r;
      next_r.s1 = {mainsRef, extSyncIn};
      next_r.s2 = r.s1;
      lvl = r.sel ? r.s2[1] : r.s2[0];
      next_r.prev = srcSel ? r.s2[1] : r.s2[0];
      next_r.sel = srcSel;
      next_r.tick = 1'b0;
      if (r.sel != srcSel) begin
         // Source changed: forget history, measure afresh
         next_r.seen = 1'b0;
         next_r.inRange = 1'b0;
         next_r.cnt = '0;
      end else if (lvl && !r.prev) begin
         next_r.period = r.cnt;
         next_r.inRange = r.seen && r.cnt >= MIN_PERIOD_CYC && r.cnt <= MAX_PERIOD_CYC;
         next_r.tick = next_r.inRange;
         next_r.seen = 1'b1;
         next_r.cnt = {{(PER_W-1){1'b0}}, 1'b1};
      end else if (r.cnt <= MAX_PERIOD_CYC) begin
         next_r.cnt = r.cnt + 1'b1;
      end else begin
         next_r.inRange = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign core.period = r.period;
   assign core.inRange = r.inRange;
   assign core.srcTick = r.tick;
endmodule // ecs_freq_meter

//--- verification/ecs_ext_control_asserts.sv
// Concurrent checks on the pins of the external control port
module ecs_ext_control_asserts (
   input wire logic mclk, // Clock
   input wire logic resetn, // Reset
   input wire logic [ecs_pkg::NCMD-1:0] cmdPinN, // Commands
   input wire logic powerIsOn, // Power
   input wire logic [3:0] limiterActive, // Limiters
   input wire logic procBusy, // Busy
   input wire logic statPowerOn, // Pin
   input wire logic statOutputOn, // Pin
   input wire logic statLimiter, // Pin
   input wire logic statBusy, // Pin
   input wire logic seqRunning, // Running
   input wire logic seqHeld, // Held
   input wire logic [1:0] seqBranch, // Branch
   input wire logic syncLocked, // Lock
   input wire logic syncTick // Tick
);
   timeunit 1ns;
   timeprecision 1ps;
   import ecs_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   power_pin_a: assert property ($past(resetn) |-> statPowerOn == $past(powerIsOn))
      else $error("power pin lags its input");
   limiter_pin_a: assert property ($past(resetn) |-> statLimiter == $past(|limiterActive))
      else $error("limiter pin wrong");
   busy_pin_a: assert property ($past(resetn) |-> statBusy == $past(procBusy))
      else $error("busy pin wrong");
   output_on_a: assert property ($fell(cmdPinN[CMD_OUT_ON]) && powerIsOn ##1 powerIsOn [*2] |=> statOutputOn)
      else $error("output not on three cycles after on edge");
   output_off_a: assert property ($fell(cmdPinN[CMD_OUT_OFF]) |-> ##3 !statOutputOn)
      else $error("output not off after off edge");
   seq_stop_a: assert property ($fell(cmdPinN[CMD_SEQ_STOP]) |-> ##3 !seqRunning && !seqHeld)
      else $error("sequence not stopped");
   seq_hold_a: assert property ($past(cmdPinN[CMD_SEQ_STOP]) && $fell(cmdPinN[CMD_SEQ_HOLD]) && seqRunning
      && cmdPinN[CMD_SEQ_STOP] ##1 cmdPinN[CMD_SEQ_STOP] [*2] |=> seqHeld)
      else $error("sequence not held");
   branch_pulse_a: assert property (seqBranch != 2'h0 |=> (seqBranch & $past(seqBranch)) == 2'h0)
      else $error("branch pulse longer than one cycle");
   tick_pulse_a: assert property (syncTick |=> !syncTick)
      else $error("lock tick longer than one cycle");
   out_on_c: cover property ($rose(statOutputOn));
   held_c: cover property ($rose(seqHeld));
   branch_c: cover property (seqBranch != 2'h0);
   lock_c: cover property (syncTick);
endmodule // ecs_ext_control_asserts

bind ecs_ext_control ecs_ext_control_asserts chk (.mclk, .resetn, .cmdPinN, .powerIsOn, .limiterActive, .procBusy,
   .statPowerOn, .statOutputOn, .statLimiter, .statBusy, .seqRunning, .seqHeld, .seqBranch, .syncLocked, .syncTick);

//--- verification/ecs_ctrl_model.sv
// Outside controller: command lines and the two sync sources
module ecs_ctrl_model (
   input wire logic mclk, // Clock
   output logic [ecs_pkg::NCMD-1:0] cmdPinN, // Command lines
   output logic extSyncIn, // External sync
   output logic mainsRef // Mains line
);
   timeunit 1ns;
   timeprecision 1ps;
   import ecs_pkg::*;
   localparam int MAINS_PER = 100;
   int extPer = 0; // Zero stops the external source
   int extCnt = 0;
   int mainsCnt = 0;
   initial begin
      cmdPinN = '1;
      extSyncIn = 1'b0;
      mainsRef = 1'b0;
   end
   always @(posedge mclk) begin
      mainsCnt <= (mainsCnt + 1) % MAINS_PER;
      mainsRef <= mainsCnt < MAINS_PER / 2;
      extCnt <= (extPer == 0) ? 0 : (extCnt + 1) % extPer;
      extSyncIn <= extPer != 0 && extCnt < extPer / 2;
   end
   // Lines idle high: a request is a falling step, low two cycles, then idle
   task automatic fire(input int i);
      @(posedge mclk);
      cmdPinN[i] <= 1'b0;
      repeat (2) @(posedge mclk);
      cmdPinN[i] <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
endmodule // ecs_ctrl_model

//--- verification/ecs_ext_control_bench.sv
// Self-checking bench of the external control port
module ecs_ext_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ecs_pkg::*;
   localparam int PMIN = 20;
   localparam int PMAX = 200;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, limiterActive;
   logic [1:0] bresp, rresp, statSeqSync, seqBranch;
   logic [NCMD-1:0] cmdPinN;
   logic extSyncIn, mainsRef, powerIsOn, procBusy, statPowerOn, statOutputOn, statLimiter, statBusy;
   logic seqRunning, seqHeld, syncLocked, syncTick, irq, seen;
   logic [31:0] seed = 32'h7e69;
   int n_mismatch = 0;
   int tests_run = 0;
   int brCnt[2] = '{0, 0};
   int ticks = 0;
   int t0;
   int pers[6] = '{20, 200, 19, 201, 300, 100};
   initial forever #4 mclk = ~mclk;
   always @(posedge mclk) begin
      brCnt[0] <= brCnt[0] + seqBranch[0];
      brCnt[1] <= brCnt[1] + seqBranch[1];
      ticks <= ticks + syncTick;
   end
   ecs_ext_control #(.MIN_PERIOD_CYC(PER_W'(PMIN)), .MAX_PERIOD_CYC(PER_W'(PMAX))) dut (.mclk, .resetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .cmdPinN, .extSyncIn, .mainsRef, .powerIsOn, .limiterActive, .procBusy,
      .statPowerOn, .statOutputOn, .statLimiter, .statBusy, .statSeqSync, .seqRunning, .seqHeld, .seqBranch,
      .syncLocked, .syncTick, .irq);
   ecs_ctrl_model ctl (.mclk, .cmdPinN, .extSyncIn, .mainsRef);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic lock_exp(input int p);
      return p >= PMIN && p <= PMAX;
   endfunction
   task automatic close_out();
      $display("Counts: %0d checks, %0d mismatches", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic timeout();
      n_mismatch++;
      $display("Error at %0t: wait ran out", $time);
      close_out();
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %0h want %0h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (++n > 50) timeout();
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      ck(32'(bresp), 32'(r), "write response");
      @(posedge mclk);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
         if (++n > 50) timeout();
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      ck(rdata, d, "read data");
      ck(32'(rresp), 32'(r), "read response");
      @(posedge mclk);
   endtask
   task automatic watch(input int n);
      seen = 1'b0;
      repeat (n) begin
         @(posedge mclk);
         seen |= syncLocked;
      end
   endtask
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
      {powerIsOn, limiterActive, procBusy} = '0;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      rd(REG_CTRL, 32'h0, RESP_OKAY);
      rd(REG_INT_EN, 32'h0, RESP_OKAY);
      rd(REG_CMD, 32'h0, RESP_OKAY);
      rd(5'h1e, 32'h0, RESP_SLVERR);
      for (int v = 3; v >= 0; v--) begin
         wr(REG_SEQSYNC, 32'(v), 4'hf, RESP_OKAY);
         ck(32'(statSeqSync), 32'(v), "seq sync");
      end
      wr(REG_SEQSYNC, 32'h3, 4'he, RESP_OKAY);
      ck(32'(statSeqSync), 32'h0, "seq sync strobe");
      $display("Done: registers");
      for (int i = 0; i < 40; i++) begin
         seed = xs(seed);
         powerIsOn <= seed[0];
         limiterActive <= seed[4:1];
         procBusy <= seed[5];
         repeat (2) @(posedge mclk);
         ck(32'(statPowerOn), 32'(seed[0]), "power pin");
         ck(32'(statLimiter), 32'(|seed[4:1]), "limiter pin");
         ck(32'(statBusy), 32'(seed[5]), "busy pin");
      end
      $display("Done: status pins");
      powerIsOn <= 1'b0;
      wr(REG_INT_EN, 32'h2, 4'hf, RESP_OKAY);
      ctl.fire(CMD_OUT_ON);
      ck(32'(statOutputOn), 32'h0, "on while power off");
      wr(REG_INT_CLR, 32'h1ff, 4'hf, RESP_OKAY);
      powerIsOn <= 1'b1;
      ck(32'(irq), 32'h0, "irq idle");
      ctl.fire(CMD_OUT_ON);
      ck(32'(statOutputOn), 32'h1, "output on");
      ck(32'(irq), 32'h1, "irq raised");
      rd(REG_INT_STAT, 32'h2, RESP_OKAY);
      wr(REG_INT_EN, 32'h0, 4'hf, RESP_OKAY);
      ck(32'(irq), 32'h0, "irq masked");
      wr(REG_INT_EN, 32'h2, 4'hf, RESP_OKAY);
      ck(32'(irq), 32'h1, "irq unmasked");
      wr(REG_INT_CLR, 32'h2, 4'hf, RESP_OKAY);
      ck(32'(irq), 32'h0, "irq cleared");
      ctl.fire(CMD_OUT_OFF);
      ck(32'(statOutputOn), 32'h0, "output off");
      $display("Done: output and interrupt");
      ctl.fire(CMD_SEQ_START);
      ck(32'({seqRunning, seqHeld}), 32'h2, "start");
      for (int b = 0; b < 2; b++) begin
         ctl.fire(CMD_BRANCH_LSB + b);
         ck(32'(brCnt[b]), 32'h1, "branch");
      end
      ctl.fire(CMD_SEQ_HOLD);
      ck(32'({seqRunning, seqHeld}), 32'h1, "hold");
      ctl.fire(CMD_BRANCH_LSB);
      ck(32'(brCnt[0]), 32'h1, "branch while held");
      ctl.fire(CMD_SEQ_START);
      ck(32'({seqRunning, seqHeld}), 32'h2, "resume");
      ctl.fire(CMD_SEQ_STOP);
      ck(32'({seqRunning, seqHeld}), 32'h0, "stop");
      wr(REG_CMD, 32'h1 << CMD_SEQ_START, 4'hf, RESP_OKAY);
      ck(32'({seqRunning, seqHeld}), 32'h2, "start by register");
      ctl.fire(CMD_SEQ_HOLD);
      ctl.fire(CMD_SEQ_STOP);
      ck(32'({seqRunning, seqHeld}), 32'h0, "stop from hold");
      $display("Done: sequence");
      wr(REG_INT_CLR, 32'h1ff, 4'hf, RESP_OKAY);
      wr(REG_CTRL, 32'h2, 4'hf, RESP_OKAY);
      foreach (pers[i]) begin
         ctl.extPer = pers[i];
         repeat (3 * pers[i] + 30) @(posedge mclk);
         watch(3 * pers[i]);
         ck(32'(seen), 32'(lock_exp(pers[i])), "lock window");
      end
      for (int m = 0; m < 4; m++) begin
         wr(REG_CTRL, 32'(m) << 1, 4'hf, RESP_OKAY);
         ck(32'(syncLocked), 32'(m == 1 || m == 2), "mode");
      end
      ctl.extPer = 0;
      wr(REG_CTRL, 32'h3, 4'hf, RESP_OKAY);
      for (int n = 0; syncLocked !== 1'b1; n++) begin
         if (n > 1000) timeout();
         @(posedge mclk);
      end
      t0 = ticks;
      repeat (1000) @(posedge mclk);
      ck(32'(ticks - t0 inside {[9:11]}), 32'h1, "mains lock ticks");
      wr(REG_CTRL, 32'h2, 4'hf, RESP_OKAY);
      watch(600);
      ck(32'(seen), 32'h0, "silent external source");
      rd(REG_INT_STAT, 32'h180, RESP_OKAY);
      wr(REG_INT_EN, 32'h100, 4'h1, RESP_OKAY);
      rd(REG_INT_EN, 32'h0, RESP_OKAY);
      wr(REG_INT_EN, 32'h100, 4'h2, RESP_OKAY);
      rd(REG_INT_EN, 32'h100, RESP_OKAY);
      ck(32'(irq), 32'h1, "irq on lock loss");
      $display("Done: sync");
      close_out();
   end
endmodule // ecs_ext_control_bench
